/* hdl/line_trigger_scan_control.sv */
`timescale 1ns/1ps
// Summary of operation
// - led shows off, red, blinking red, blinking orange, green blinking or steady green
// - internal mode fires lines from a timer set by the line period
// - external mode takes gpio one, the grabber, or the encoder as source
// - external edges qualified as rising, falling or both
// - triggers above the ceiling are dropped; lines run at most at it
// - the spacing of qualified triggers, dropped ones included, is measured and readable
// - the ceiling follows link lanes: 140, 280 or 300 kHz
// - a zero rate stops lines cleanly, with no partial line
// - direction comes from a setting, gpio two, or the encoder
// - internal direction source uses the software direction bit
// - a direction switch completes well under one millisecond
// - per-row delays follow the current scan direction
// - alignment factor in sixteenths of a row, from 0 to 1.5
// - alignment factor changes refused while acquisition runs
// - pixels leave as 8-bit or 12-bit gray
module line_trigger_scan_control #(
    parameter int ROWS = 4,
    parameter int DLY_W = 8,
    parameter int BLINK_HALF = lts_pkg::BLINK_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [lts_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [lts_pkg::DATA_W-1:0] writedata,
    output logic [lts_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic gpioLine1,
    input wire logic gpioLine2,
    input wire logic grabberTrigger,
    input wire logic [1:0] linkConfig,
    input wire logic selfTestFail,
    input wire logic overTemp,
    input wire logic booting,
    input wire logic hostReady,
    input wire logic linkUp,
    input wire logic [lts_pkg::PIX_W-1:0] pixelIn,
    input wire logic pixelInValid,
    output logic lineTrigger,
    output logic scanForward,
    output logic [ROWS-1:0][DLY_W-1:0] rowDelay,
    output logic [lts_pkg::PIX_W-1:0] pixelOut,
    output logic pixelOutValid,
    output logic ledRed,
    output logic ledGreen,
    output logic irq
);
    import lts_pkg::*;

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic triggerOriginSelect;
        logic [1:0] externalTriggerInputSelect;
        logic [1:0] triggerEdgeSelect;
        logic [1:0] directionOriginSelect;
        logic internalDirectionSetting;
        logic acq;
        logic fmt12;
        logic [PERIOD_W-1:0] period;
        logic [PERIOD_W-1:0] tmr;
        logic [PERIOD_W-1:0] holdoff;
        logic [PERIOD_W-1:0] since;
        logic [PERIOD_W-1:0] observedLineFrequency;
        logic [CORR_W-1:0] rowAlignmentFactor;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic lvlPrev;
        logic fwd;
        logic line;
        logic [ROWS-1:0][DLY_W-1:0] dly;
        logic [PIX_W-1:0] pix;
        logic pixV;
        logic [BLINK_W-1:0] blink;
        logic blinkOn;
        led_mode_e led;
        logic ledR;
        logic ledG;
    } state_s;
    state_s q;
    state_s d;

    logic [1:0] pinSync;
    logic encStep;
    logic encFwd;
    logic trigLevel;
    logic rise;
    logic fall;
    logic extTrig;
    logic intTrig;
    logic trigQual;
    logic accept;
    logic wrHit;
    logic dirSel;
    logic [ST_W-1:0] stSet;
    logic [ST_W-1:0] stClr;
    logic [PERIOD_W-1:0] minPeriod;

    // both gpio pins synchronised before anything looks at them
    pin_sync #(.W(2)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .pinIn({gpioLine2, gpioLine1}),
        .pinSync(pinSync)
    );

    // encoder fed from both synchronised pins
    quad_decoder u_quad (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .phaseA(pinSync[0]),
        .phaseB(pinSync[1]),
        .step(encStep),
        .forward(encFwd)
    );

    // least line period for the present link
    always_comb begin
        case (linkConfig)
            LINK_TWO_FIBRE: minPeriod = PERIOD_W'(MINP_TWO);
            LINK_COPPER: minPeriod = PERIOD_W'(MINP_COPPER);
            default: minPeriod = PERIOD_W'(MINP_ONE);
        endcase
    end

    // external trigger source and edge qualification
    always_comb begin
        case (q.externalTriggerInputSelect)
            SRC_LINK: trigLevel = grabberTrigger;
            default: trigLevel = pinSync[0];
        endcase
        rise = trigLevel & ~q.lvlPrev;
        fall = ~trigLevel & q.lvlPrev;
        case (q.triggerEdgeSelect)
            EDGE_FALL: extTrig = fall;
            EDGE_ANY: extTrig = rise | fall;
            default: extTrig = rise;
        endcase
        if (q.externalTriggerInputSelect == SRC_ENC) begin
            extTrig = encStep;
        end
    end

    // direction source
    always_comb begin
        case (q.directionOriginSelect)
            DIRSRC_GPIO: dirSel = pinSync[1];
            DIRSRC_ENC: dirSel = encFwd;
            default: dirSel = q.internalDirectionSetting;
        endcase
    end

    assign intTrig = (q.period != '0) && (q.tmr >= q.period - 1'b1);
    assign trigQual = q.triggerOriginSelect ? extTrig : intTrig;
    assign accept = trigQual & q.acq & (q.holdoff == '0);
    assign wrHit = write & q.ack & ce;

    // next state of the whole block
    always_comb begin
        d = q;
        d.ack = (read | write) & ~q.ack;
        d.lvlPrev = trigLevel;
        d.line = accept;
        d.pixV = 1'b0;
        stSet = '0;
        stClr = '0;
        // internal timer; a zero period halts it cleanly
        if (q.period == '0 || intTrig) begin
            d.tmr = '0;
        end else begin
            d.tmr = q.tmr + 1'b1;
        end
        // holdoff enforces the line-rate ceiling
        if (accept) begin
            d.holdoff = minPeriod - 1'b1;
        end else if (q.holdoff != '0) begin
            d.holdoff = q.holdoff - 1'b1;
        end
        // spacing of qualified triggers, dropped ones included, saturating
        if (trigQual) begin
            d.observedLineFrequency = q.since + 1'b1;
            d.since = '0;
        end else if (q.since != '1) begin
            d.since = q.since + 1'b1;
        end
        stSet[ST_LINE] = accept;
        stSet[ST_DROP] = trigQual & q.acq & ~accept;
        // direction takes effect on the next edge
        d.fwd = dirSel;
        stSet[ST_DIRCHG] = dirSel ^ q.fwd;
        for (int i = 0; i < ROWS; i++) begin
            if (q.fwd) begin
                d.dly[i] = DLY_W'(q.rowAlignmentFactor * i);
            end else begin
                d.dly[i] = DLY_W'(q.rowAlignmentFactor * (ROWS - 1 - i));
            end
        end
        // pixel format
        if (pixelInValid) begin
            d.pixV = 1'b1;
            if (q.fmt12) begin
                d.pix = pixelIn;
            end else begin
                d.pix = PIX_W'(pixelIn[PIX_W-1 -: GRAY8_W]);
            end
        end
        // register reads are captured in the wait cycle
        if (read & ~q.ack) begin
            case (address)
                REG_CTRL: d.rdata = DATA_W'({q.fmt12, q.acq, q.internalDirectionSetting,
                    q.directionOriginSelect, q.triggerEdgeSelect,
                    q.externalTriggerInputSelect, q.triggerOriginSelect});
                REG_LINE_PERIOD: d.rdata = DATA_W'(q.period);
                REG_ALIGN: d.rdata = DATA_W'(q.rowAlignmentFactor);
                REG_OBSERVED: d.rdata = DATA_W'(q.observedLineFrequency);
                REG_STATUS: d.rdata = DATA_W'(q.status);
                REG_MASK: d.rdata = DATA_W'(q.mask);
                REG_INFO: d.rdata = DATA_W'({q.led, linkConfig, q.fwd});
                default: d.rdata = '0;
            endcase
        end
        // register writes take effect at the ack edge
        if (wrHit) begin
            case (address)
                REG_CTRL: begin
                    d.triggerOriginSelect = writedata[CTL_EXT];
                    d.externalTriggerInputSelect = writedata[CTL_SRC +: 2];
                    d.triggerEdgeSelect = writedata[CTL_EDGE +: 2];
                    d.directionOriginSelect = writedata[CTL_DIRSRC +: 2];
                    d.internalDirectionSetting = writedata[CTL_DIR];
                    d.acq = writedata[CTL_ACQ];
                    d.fmt12 = writedata[CTL_FMT12];
                end
                REG_LINE_PERIOD: d.period = writedata[PERIOD_W-1:0];
                REG_ALIGN: begin
                    if (q.acq) begin
                        stSet[ST_REFUSE] = 1'b1;
                    end else if (writedata[CORR_W-1:0] > CORR_MAX
                                 || writedata[DATA_W-1:CORR_W] != '0) begin
                        d.rowAlignmentFactor = CORR_MAX;
                    end else begin
                        d.rowAlignmentFactor = writedata[CORR_W-1:0];
                    end
                end
                REG_STATUS: stClr = writedata[ST_W-1:0];
                REG_MASK: d.mask = writedata[ST_W-1:0];
                default: ;
            endcase
        end
        // sticky status; a set in the clearing cycle wins
        d.status = (q.status & ~stClr) | stSet;
        // led mode by priority
        if (selfTestFail) begin
            d.led = LED_RED;
        end else if (overTemp) begin
            d.led = LED_RED_BLINK;
        end else if (booting) begin
            d.led = LED_ORANGE_BLINK;
        end else if (!hostReady) begin
            d.led = LED_OFF;
        end else if (linkUp) begin
            d.led = LED_GREEN;
        end else begin
            d.led = LED_GREEN_BLINK;
        end
        if (32'(q.blink) >= BLINK_HALF - 1) begin
            d.blink = '0;
            d.blinkOn = ~q.blinkOn;
        end else begin
            d.blink = q.blink + 1'b1;
        end
        case (q.led)
            LED_RED: {d.ledR, d.ledG} = 2'h2;
            LED_RED_BLINK: {d.ledR, d.ledG} = {q.blinkOn, 1'b0};
            LED_ORANGE_BLINK: {d.ledR, d.ledG} = {2{q.blinkOn}};
            LED_GREEN_BLINK: {d.ledR, d.ledG} = {1'b0, q.blinkOn};
            LED_GREEN: {d.ledR, d.ledG} = 2'h1;
            default: {d.ledR, d.ledG} = 2'h0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // outputs
    assign waitrequest = (read | write) & ~(q.ack & ce);
    assign readdata = q.rdata;
    assign lineTrigger = q.line;
    assign scanForward = q.fwd;
    assign rowDelay = q.dly;
    assign pixelOut = q.pix;
    assign pixelOutValid = q.pixV;
    assign ledRed = q.ledR;
    assign ledGreen = q.ledG;
    assign irq = |(q.status & q.mask);

    // helper: cycles since the last line trigger
    logic [PERIOD_W-1:0] gapCnt;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            gapCnt <= '1;
        end else if (ce) begin
            if (q.line) begin
                gapCnt <= PERIOD_W'(1);
            end else if (gapCnt != '1) begin
                gapCnt <= gapCnt + 1'b1;
            end
        end
    end

    property p_rate_cap;
        @(posedge clock) disable iff (!rstn || !ce)
        lineTrigger |-> gapCnt >= minPeriod;
    endproperty
    a_rate_cap: assert property (p_rate_cap) else $error("line spacing under ceiling");

    property p_zero_stop;
        @(posedge clock) disable iff (!rstn || !ce)
        (!q.triggerOriginSelect && q.period == '0) [*2] |-> !lineTrigger;
    endproperty
    a_zero_stop: assert property (p_zero_stop) else $error("line with zero period");

    property p_one_per_edge;
        @(posedge clock) disable iff (!rstn || !ce)
        lineTrigger |=> !lineTrigger;
    endproperty
    a_one_per_edge: assert property (p_one_per_edge) else $error("double line");

    property p_rise_only;
        @(posedge clock) disable iff (!rstn || !ce)
        (q.triggerOriginSelect && q.triggerEdgeSelect == EDGE_RISE
         && q.externalTriggerInputSelect == SRC_LINK && accept)
        |-> grabberTrigger && !$past(grabberTrigger);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("line on non-rising edge");

    property p_refuse;
        @(posedge clock) disable iff (!rstn || !ce)
        (wrHit && address == REG_ALIGN && q.acq)
        |=> $stable(q.rowAlignmentFactor) && q.status[ST_REFUSE];
    endproperty
    a_refuse: assert property (p_refuse) else $error("factor changed while running");

    property p_factor_range;
        @(posedge clock) disable iff (!rstn || !ce)
        q.rowAlignmentFactor <= CORR_MAX;
    endproperty
    a_factor_range: assert property (p_factor_range) else $error("factor above 1.5");

    sequence s_dir_held;
        (q.directionOriginSelect == DIRSRC_INT) [*2];
    endsequence
    property p_dir_int;
        @(posedge clock) disable iff (!rstn || !ce)
        s_dir_held |-> scanForward == $past(q.internalDirectionSetting);
    endproperty
    a_dir_int: assert property (p_dir_int) else $error("direction not following setting");

    property p_gray8;
        @(posedge clock) disable iff (!rstn || !ce)
        (pixelInValid && !q.fmt12) |=> pixelOutValid && pixelOut[PIX_W-1:GRAY8_W] == '0;
    endproperty
    a_gray8: assert property (p_gray8) else $error("8-bit pixel has high bits");

    property p_led_fail;
        @(posedge clock) disable iff (!rstn || !ce)
        selfTestFail [*3] |-> ledRed && !ledGreen;
    endproperty
    a_led_fail: assert property (p_led_fail) else $error("self-test fail not red");

    property p_measure;
        @(posedge clock) disable iff (!rstn || !ce)
        (trigQual && q.since != '1) |=> q.observedLineFrequency == $past(q.since) + 1'b1;
    endproperty
    a_measure: assert property (p_measure) else $error("measured spacing wrong");
endmodule : line_trigger_scan_control

/* hdl/lts_pkg.sv */
package lts_pkg;
    // clock and register bus geometry
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 32;
    localparam int PERIOD_W = 24;
    localparam int CORR_W = 5;
    localparam int PIX_W = 12;
    localparam int GRAY8_W = 8;
    localparam int ST_W = 4;
    localparam int BLINK_W = 26;

    // register word addresses
    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_LINE_PERIOD = 3'h1;
    localparam logic [ADDR_W-1:0] REG_ALIGN = 3'h2;
    localparam logic [ADDR_W-1:0] REG_OBSERVED = 3'h3;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] REG_MASK = 3'h5;
    localparam logic [ADDR_W-1:0] REG_INFO = 3'h6;

    // control field positions
    localparam int CTL_EXT = 0;
    localparam int CTL_SRC = 1;
    localparam int CTL_EDGE = 3;
    localparam int CTL_DIRSRC = 5;
    localparam int CTL_DIR = 7;
    localparam int CTL_ACQ = 8;
    localparam int CTL_FMT12 = 9;

    // status bit positions
    localparam int ST_LINE = 0;
    localparam int ST_DROP = 1;
    localparam int ST_REFUSE = 2;
    localparam int ST_DIRCHG = 3;

    // selector codes
    localparam logic [1:0] SRC_GPIO = 2'h0;
    localparam logic [1:0] SRC_LINK = 2'h1;
    localparam logic [1:0] SRC_ENC = 2'h2;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_ANY = 2'h2;
    localparam logic [1:0] DIRSRC_INT = 2'h0;
    localparam logic [1:0] DIRSRC_GPIO = 2'h1;
    localparam logic [1:0] DIRSRC_ENC = 2'h2;
    localparam logic [1:0] LINK_ONE_FIBRE = 2'h0;
    localparam logic [1:0] LINK_TWO_FIBRE = 2'h1;
    localparam logic [1:0] LINK_COPPER = 2'h2;

    // line-rate ceilings and the least line period in cycles (rounded up)
    localparam int RATE_ONE_FIBRE_HZ = 140_000;
    localparam int RATE_TWO_FIBRE_HZ = 280_000;
    localparam int RATE_COPPER_HZ = 300_000;
    localparam int MINP_ONE = (CLK_HZ + RATE_ONE_FIBRE_HZ - 1) / RATE_ONE_FIBRE_HZ;
    localparam int MINP_TWO = (CLK_HZ + RATE_TWO_FIBRE_HZ - 1) / RATE_TWO_FIBRE_HZ;
    localparam int MINP_COPPER = (CLK_HZ + RATE_COPPER_HZ - 1) / RATE_COPPER_HZ;

    // alignment factor in sixteenths of a row, 1.5 rows at most
    localparam logic [CORR_W-1:0] CORR_MAX = 5'h18;

    // led blink half period
    localparam int BLINK_HALF_NS = 250_000_000;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        LED_OFF,
        LED_RED,
        LED_RED_BLINK,
        LED_ORANGE_BLINK,
        LED_GREEN_BLINK,
        LED_GREEN
    } led_mode_e;
endpackage : lts_pkg

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinSync
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_s;
    sync_s q;
    sync_s d;

    // two flops per pin; only the second stage is read
    always_comb begin
        d.stage1 = pinIn;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign pinSync = q.stage2;
endmodule : pin_sync

/* hdl/quad_decoder.sv */
`timescale 1ns/1ps
module quad_decoder (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic phaseA,
    input wire logic phaseB,
    output logic step,
    output logic forward
);
    typedef struct packed {
        logic prevA;
        logic step;
        logic forward;
    } quad_s;
    quad_s q;
    quad_s d;

    // one step per rising phase a; phase b level gives the direction
    always_comb begin
        d = q;
        d.prevA = phaseA;
        d.step = phaseA & ~q.prevA;
        if (phaseA & ~q.prevA) begin
            d.forward = ~phaseB;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign step = q.step;
    assign forward = q.forward;
endmodule : quad_decoder

/* bench/grabber_model.sv */
`timescale 1ns/1ps
module grabber_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [15:0] spacing,
    output logic trig
);
    logic [15:0] count_q;
    // period counter; the link stays quiet while spacing is zero
    always_ff @(posedge clock) begin
        if (!rstn || spacing == 16'h0) begin
            count_q <= 16'h0;
        end else if (count_q >= spacing - 16'h1) begin
            count_q <= 16'h0;
        end else begin
            count_q <= count_q + 16'h1;
        end
    end
    // ten-cycle trigger pulse at the start of each period
    assign trig = (spacing != 16'h0) && (count_q < 16'ha);
endmodule : grabber_model

/* bench/line_trigger_scan_control_tb.sv */
`timescale 1ns/1ps
module line_trigger_scan_control_tb;
    import lts_pkg::*;
    logic clock = 0, rstn = 0, ce = 1, read = 0, write = 0, waitrequest;
    logic [ADDR_W-1:0] address = '0;
    logic [DATA_W-1:0] writedata = '0, readdata, r;
    logic gpioLine1 = 0, gpioLine2 = 0, grabberTrigger, pixelInValid = 0, pixelOutValid;
    logic selfTestFail = 0, overTemp = 0, booting = 0, hostReady = 1, linkUp = 1;
    logic lineTrigger, scanForward, ledRed, ledGreen, irq;
    logic [1:0] linkConfig = 2'h0;
    logic [PIX_W-1:0] pixelIn = '0, pixelOut;
    logic [3:0][7:0] rowDelay;
    logic [15:0] spacing = 16'h0;
    logic [31:0] rdQ[$], pixQ[$];
    int fails = 0, nTests = 0, cyc = 0, nLines = 0, lastCyc = 0, gap = 0, n = 0;
    int seed = 32'h0128;
    int minP[3] = '{MINP_ONE, MINP_TWO, MINP_COPPER};
    logic [7:0] ledTab[6] = '{8'h33, 8'h4b, 8'h67, 8'h01, 8'h82, 8'ha3};

    line_trigger_scan_control #(.ROWS(4), .DLY_W(8), .BLINK_HALF(4)) dut (
        .clock(clock), .rstn(rstn), .ce(ce), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .gpioLine1(gpioLine1), .gpioLine2(gpioLine2),
        .grabberTrigger(grabberTrigger), .linkConfig(linkConfig),
        .selfTestFail(selfTestFail), .overTemp(overTemp), .booting(booting),
        .hostReady(hostReady), .linkUp(linkUp), .pixelIn(pixelIn),
        .pixelInValid(pixelInValid), .lineTrigger(lineTrigger),
        .scanForward(scanForward), .rowDelay(rowDelay), .pixelOut(pixelOut),
        .pixelOutValid(pixelOutValid), .ledRed(ledRed), .ledGreen(ledGreen), .irq(irq)
    );
    grabber_model link (.clock(clock), .rstn(rstn), .spacing(spacing), .trig(grabberTrigger));

    // clock of 5 ns period
    always #2.5 clock = ~clock;

    task automatic stop_test;
        if (fails == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        @(posedge clock);
        // only the watchdog ends a wait that never answers
        while (waitrequest !== 1'b0) @(posedge clock);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        rdQ.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic [31:0] ctl(input logic [1:0] s, g, ds, input logic e, d, a);
        ctl = '0;
        ctl[CTL_EXT] = e;
        ctl[CTL_SRC+:2] = s;
        ctl[CTL_EDGE+:2] = g;
        ctl[CTL_DIRSRC+:2] = ds;
        ctl[CTL_DIR] = d;
        ctl[CTL_ACQ] = a;
    endfunction : ctl

    task automatic idle(input int k);
        repeat (k) @(posedge clock);
    endtask : idle

    // read data and pixels compared against the oldest note
    always @(posedge clock) begin
        cyc++;
        if (read === 1'b1 && waitrequest === 1'b0) check(readdata, rdQ.pop_front());
        if (pixelOutValid === 1'b1) check({20'h0, pixelOut}, pixQ.pop_front());
        if (lineTrigger === 1'b1) begin
            nLines++;
            gap = cyc - lastCyc;
            lastCyc = cyc;
        end
    end

    // watchdog
    initial begin
        #500000;
        fails++;
        stop_test();
    end

    initial begin
        idle(3);
        rstn <= 1'b1;
        rd(REG_CTRL, 32'h0);
        rd(3'h7, 32'h0);
        wr(3'h7, 32'h5);
        for (int i = 0; i < 6; i++) begin
            {selfTestFail, overTemp, booting, hostReady, linkUp} <= ledTab[i][4:0];
            idle(12);
            rd(REG_INFO, {26'h0, ledTab[i][7:5], 3'h0});
            if (i == 0 || i == 5) check({ledRed, ledGreen}, (i == 0) ? 2'b10 : 2'b01);
        end
        for (int f = 0; f < 2; f++) begin
            wr(REG_CTRL, 32'(f) << CTL_FMT12);
            for (int i = 0; i < 8; i++) begin
                @(posedge clock);
                r = $random(seed);
                pixelIn <= r[11:0];
                pixelInValid <= 1'b1;
                pixQ.push_back(f ? {20'h0, r[11:0]} : {24'h0, r[11:4]});
            end
            @(posedge clock);
            pixelInValid <= 1'b0;
        end
        wr(REG_ALIGN, 32'h1f);
        rd(REG_ALIGN, 32'h18);
        wr(REG_ALIGN, 32'h10);
        for (int d = 1; d >= 0; d--) begin
            wr(REG_CTRL, ctl(SRC_GPIO, EDGE_RISE, DIRSRC_INT, 1'b0, d[0], 1'b0));
            idle(4);
            check(scanForward, d[0]);
            for (int i = 0; i < 4; i++) check(rowDelay[i], d ? 8'(16 * i) : 8'(16 * (3 - i)));
        end
        wr(REG_CTRL, ctl(SRC_GPIO, EDGE_RISE, DIRSRC_GPIO, 1'b0, 1'b0, 1'b0));
        for (int d = 1; d >= 0; d--) begin
            gpioLine2 <= d[0];
            idle(8);
            check(scanForward, d[0]);
        end
        // host sees the reversal flag before clearing it
        rd(REG_STATUS, 32'h8);
        wr(REG_STATUS, 32'hf);
        wr(REG_MASK, 32'h4);
        wr(REG_CTRL, ctl(SRC_GPIO, EDGE_RISE, DIRSRC_INT, 1'b0, 1'b0, 1'b1));
        wr(REG_ALIGN, 32'h8);
        rd(REG_ALIGN, 32'h10);
        idle(2);
        check(irq, 1'b1);
        wr(REG_STATUS, 32'h4);
        idle(2);
        check(irq, 1'b0);
        r = $random(seed);
        wr(REG_LINE_PERIOD, {8'h0, r[23:0]});
        rd(REG_LINE_PERIOD, {8'h0, r[23:0]});
        wr(REG_LINE_PERIOD, 32'd1500);
        n = nLines + 3;
        for (int i = 0; i < 10000 && nLines < n; i++) @(posedge clock);
        check(gap, 1500);
        rd(REG_OBSERVED, 32'd1500);
        wr(REG_LINE_PERIOD, 32'h0);
        idle(10);
        n = nLines;
        idle(4000);
        check(nLines, n);
        for (int g = 0; g < 3; g++) begin
            wr(REG_CTRL, ctl(SRC_GPIO, 2'(g), DIRSRC_INT, 1'b1, 1'b0, 1'b1));
            n = nLines;
            gpioLine1 <= 1'b1;
            idle(2000);
            gpioLine1 <= 1'b0;
            idle(2000);
            check(nLines - n, (g == 2) ? 2 : 1);
        end
        wr(REG_CTRL, ctl(SRC_ENC, EDGE_RISE, DIRSRC_ENC, 1'b1, 1'b0, 1'b1));
        for (int d = 1; d >= 0; d--) begin
            n = nLines;
            gpioLine2 <= !d[0];
            idle(4);
            gpioLine1 <= 1'b1;
            idle(2000);
            check(scanForward, d[0]);
            check(nLines - n, 1);
            gpioLine1 <= 1'b0;
            idle(4);
        end
        wr(REG_CTRL, ctl(SRC_LINK, EDGE_RISE, DIRSRC_INT, 1'b1, 1'b0, 1'b1));
        wr(REG_STATUS, 32'hf);
        spacing <= 16'd100;
        for (int l = 0; l < 3; l++) begin
            linkConfig <= 2'(l);
            idle(7000);
            check(gap >= minP[l] && gap < minP[l] + 100, 1'b1);
        end
        rd(REG_OBSERVED, 32'd100);
        rd(REG_STATUS, 32'h3);
        spacing <= 16'd2000;
        idle(7000);
        check(gap, 2000);
        // clock enable low freezes the led path
        spacing <= 16'h0;
        ce <= 1'b0;
        selfTestFail <= 1'b1;
        idle(8);
        check({ledRed, ledGreen}, 2'b01);
        ce <= 1'b1;
        idle(4);
        check({ledRed, ledGreen}, 2'b10);
        // reset in mid-run clears outputs and registers
        rstn <= 1'b0;
        idle(3);
        check({ledRed, ledGreen, lineTrigger, irq}, 4'h0);
        rstn <= 1'b1;
        rd(REG_CTRL, 32'h0);
        idle(4);
        check({ledRed, ledGreen}, 2'b10);
        stop_test();
    end
endmodule : line_trigger_scan_control_tb
